//--- common/gps_map.vh
// Constants for the general I/O port block: routing codes, field positions, timing.
// Assumes inclusion by the port modules only; holds definitions only.
`ifndef GPS_MAP_VH
`define GPS_MAP_VH

// ----------------------------------------------------------------------------
// Strobe routing field codes
// ----------------------------------------------------------------------------
`define GPS_ROUTE_DEFAULT 2'h0
`define GPS_ROUTE_STROBE 2'h1
`define GPS_ROUTE_ONE_BIT 2'h2
`define GPS_ROUTE_TWO_BIT 2'h3
`define GPS_ROUTE_STATIC_BIT 1

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define GPS_NIB_LO_MSB 3
`define GPS_NIB_HI_LSB 4
`define GPS_NIB_HI_MSB 7
`define GPS_DATA_RESET 8'h00
`define GPS_PIN_IDLE 1'h1

// ----------------------------------------------------------------------------
// Timing in clock cycles (display or system clock, one cycle each)
// ----------------------------------------------------------------------------
`define GPS_CAPTURE_DELAY 4'h2
`define GPS_STROBE_LOW 4'h2
`define GPS_HOLD_HALF 4'h1
`define GPS_IN_CYCLE 5'h13
`define GPS_OUT_CYCLE 5'h07

`endif

//--- src/gps_port.v
// General I/O port of the graphics controller: shared-line strobed port and static outputs.
// Assumes register writes arrive as one-cycle strobes on this clock and pins are resolved
// from output enables outside.
//
// Notes on behaviour
// - PCI input mode: trigger write latches upper data lines into port nibble two clocks later.
// - Trigger write also drives low port nibble onto lower lines and pulses the strobe.
// - PCI output mode: low nibble driven at once, strobe rises after two, half-clock hold.
// - VL input port: read enabled by its bit, strobe output when routing is 01b.
// - Read of DAC write index asserts strobe; buffer data reaches bus, about 18-20 clocks.
// - PCI two-bit mode on routing bit one drives trigger bits 0 and 1 continuously.
// - VL output port: each trigger write presents its byte on upper system data byte.
// - Routing 11b on VL drives trigger bits 0 and 1; one replaces ROM chip select.
// - Routing 10b on VL drives trigger bit 0 on one pin; ROM chip select stays.
// - After reset with routing 00b the general output pins are driven high.
`timescale 1ns/100ps
`include "gps_map.vh"
module gps_port #(
  parameter IN_CYCLES = 19,
  parameter OUT_CYCLES = 7
) (
  // Clock and reset.
  input wire clock_i,
  input wire rst_n_i,
  // Configuration bits.
  input wire pci_mode_i,
  input wire [1:0] strobe_routing_field_i,
  input wire input_read_enable_i,
  input wire local_bus_other_use_i,
  // Register writes and reads.
  input wire port_trigger_we_i,
  input wire [7:0] port_trigger_wdata_i,
  input wire port_data_we_i,
  input wire [7:0] port_data_wdata_i,
  input wire dac_index_read_i,
  // Register read-back.
  output reg [7:0] port_trigger_register_o,
  output reg [7:0] port_data_register_o,
  output reg [7:0] input_read_data_o,
  output reg input_read_valid_o,
  output reg port_busy_o,
  // Local data lines.
  input wire [7:0] local_data_lines_i,
  output reg [3:0] local_data_lines_o,
  output reg [3:0] local_data_lines_oe_o,
  // System data bus.
  input wire [7:0] system_data_bus_i,
  output reg [7:0] system_data_bus_hi_o,
  output reg system_data_bus_hi_oe_o,
  // Strobe and static output pins.
  output reg port_write_strobe_o,
  output reg port_io_strobe_o,
  output reg rom_chip_select_n_o,
  input wire rom_select_req_i
);

  // ----------------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------------
  wire [7:0] ld_sync;
  wire [7:0] sd_sync;

  gps_sync #(.WIDTH(8)) u_ld_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(local_data_lines_i),
    .level_o(ld_sync)
  );

  gps_sync #(.WIDTH(8)) u_sd_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(system_data_bus_i),
    .level_o(sd_sync)
  );

  // ----------------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------------
  wire route_strobe = (strobe_routing_field_i == `GPS_ROUTE_STROBE);
  // PCI static mode only needs routing bit one, so it covers both 10b and 11b.
  wire pci_static = pci_mode_i && strobe_routing_field_i[`GPS_ROUTE_STATIC_BIT];
  wire vl_two_bit = !pci_mode_i && (strobe_routing_field_i == `GPS_ROUTE_TWO_BIT);
  wire vl_one_bit = !pci_mode_i && (strobe_routing_field_i == `GPS_ROUTE_ONE_BIT);
  // The controller must clear other bus users first; the port stays quiet otherwise.
  wire port_ok = route_strobe && !local_bus_other_use_i;

  wire pci_go = pci_mode_i && port_ok && port_trigger_we_i;
  wire vl_out_go = !pci_mode_i && port_ok && port_trigger_we_i;
  wire vl_in_go = !pci_mode_i && port_ok && input_read_enable_i && dac_index_read_i;

  // ----------------------------------------------------------------------------
  // Sequence timer
  // ----------------------------------------------------------------------------
  localparam PH_IDLE = 2'b00;
  localparam PH_PCI = 2'b01;
  localparam PH_VL_OUT = 2'b10;
  localparam PH_VL_IN = 2'b11;

  reg [1:0] phase_q;
  reg [4:0] load_count;
  wire tmr_busy;
  wire [4:0] tmr_left;

  // PCI length covers low time plus the half-clock hold, rounded up to a cycle.
  always @* begin
    if (pci_go) begin
      load_count = {1'b0, `GPS_STROBE_LOW} + {1'b0, `GPS_HOLD_HALF};
    end else if (vl_out_go) begin
      load_count = OUT_CYCLES[4:0];
    end else begin
      load_count = IN_CYCLES[4:0];
    end
  end

  gps_timer #(.WIDTH(5)) u_timer (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .load_i(pci_go || vl_out_go || vl_in_go),
    .count_i(load_count),
    .busy_o(tmr_busy),
    .left_o(tmr_left)
  );

  // Elapsed cycles for PCI sequence: total minus what is left.
  wire [4:0] pci_elapsed = {1'b0, `GPS_STROBE_LOW} + {1'b0, `GPS_HOLD_HALF} - tmr_left;

  // ----------------------------------------------------------------------------
  // Phase tracking
  // ----------------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      phase_q <= PH_IDLE;
    end else if (pci_go) begin
      phase_q <= PH_PCI;
    end else if (vl_out_go) begin
      phase_q <= PH_VL_OUT;
    end else if (vl_in_go) begin
      phase_q <= PH_VL_IN;
    end else if (!tmr_busy) begin
      phase_q <= PH_IDLE;
    end
  end

  // The registered strobe lags this term by one cycle, so each phase ends one count early here.
  wire strobe_low = tmr_busy && ((phase_q == PH_PCI) ? (pci_elapsed + 5'h01 < {1'b0, `GPS_STROBE_LOW}) :
    (tmr_left > 5'h01));

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  // Capture lands two cycles after the trigger, at the strobe rising edge.
  wire capture = tmr_busy && (phase_q == PH_PCI) && (pci_elapsed + 5'h01 == {1'b0, `GPS_CAPTURE_DELAY});

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      port_trigger_register_o <= `GPS_DATA_RESET;
      port_data_register_o <= `GPS_DATA_RESET;
    end else begin
      if (port_trigger_we_i) begin
        port_trigger_register_o <= port_trigger_wdata_i;
      end
      // Hardware capture of the upper nibble takes precedence over a software write there.
      if (port_data_we_i) begin
        port_data_register_o <= port_data_wdata_i;
      end
      if (capture) begin
        port_data_register_o[`GPS_NIB_HI_MSB:`GPS_NIB_HI_LSB] <=
          ld_sync[`GPS_NIB_HI_MSB:`GPS_NIB_HI_LSB];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------------
  // Idle pins sit high so active-low enables outside stay off.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      local_data_lines_o <= 4'h0;
      local_data_lines_oe_o <= 4'h0;
      system_data_bus_hi_o <= 8'h00;
      system_data_bus_hi_oe_o <= 1'b0;
      port_write_strobe_o <= `GPS_PIN_IDLE;
      port_io_strobe_o <= `GPS_PIN_IDLE;
      rom_chip_select_n_o <= `GPS_PIN_IDLE;
      input_read_data_o <= 8'h00;
      input_read_valid_o <= 1'b0;
      port_busy_o <= 1'b0;
    end else begin
      port_busy_o <= tmr_busy;
      // Lower nibble goes out with the trigger and holds through the half-clock hold.
      if (pci_go) begin
        local_data_lines_o <= port_data_register_o[`GPS_NIB_LO_MSB:0];
        local_data_lines_oe_o <= 4'hF;
      end else if (!(tmr_busy && phase_q == PH_PCI && pci_elapsed < {1'b0, `GPS_STROBE_LOW})) begin
        local_data_lines_oe_o <= 4'h0;
      end
      // Byte goes to the latch at once; either strobe edge sees stable data.
      if (vl_out_go) begin
        system_data_bus_hi_o <= port_trigger_wdata_i;
        system_data_bus_hi_oe_o <= 1'b1;
      end else if (!(tmr_busy && phase_q == PH_VL_OUT)) begin
        system_data_bus_hi_oe_o <= 1'b0;
      end
      // Buffer data is taken from the bus while the input strobe is low.
      input_read_valid_o <= tmr_busy && (phase_q == PH_VL_IN) && (tmr_left == 5'h01);
      if (tmr_busy && phase_q == PH_VL_IN) begin
        input_read_data_o <= sd_sync;
      end
      // Strobe and static output selection by mode.
      if (pci_static) begin
        port_io_strobe_o <= port_trigger_register_o[0];
        port_write_strobe_o <= port_trigger_register_o[1];
        rom_chip_select_n_o <= rom_select_req_i ? 1'b0 : 1'b1;
      end else if (vl_two_bit) begin
        port_io_strobe_o <= port_trigger_register_o[0];
        rom_chip_select_n_o <= port_trigger_register_o[1];
        port_write_strobe_o <= `GPS_PIN_IDLE;
      end else if (vl_one_bit) begin
        port_io_strobe_o <= port_trigger_register_o[0];
        rom_chip_select_n_o <= !rom_select_req_i;
        port_write_strobe_o <= `GPS_PIN_IDLE;
      end else begin
        rom_chip_select_n_o <= pci_mode_i ? `GPS_PIN_IDLE : !rom_select_req_i;
        port_write_strobe_o <= !((pci_go || strobe_low) && (pci_mode_i && route_strobe));
        port_io_strobe_o <= !((vl_out_go || vl_in_go || strobe_low) && !pci_mode_i && route_strobe);
      end
    end
  end

endmodule

//--- src/gps_sync.v
// Three-stage synchroniser for a bus of pins coming from outside the clock domain.
// Assumes a single clock; a change is accepted once stages two and three agree.
`timescale 1ns/100ps
module gps_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset.
  input wire clock_i,
  input wire rst_n_i,
  // Pin side and filtered result.
  input wire [WIDTH-1:0] pin_i,
  output reg [WIDTH-1:0] level_o
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // The first stage feeds only the second, so no logic sees a metastable value.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      level_o <= {WIDTH{1'b0}};
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end

endmodule

//--- src/gps_timer.v
// Down counter that times one strobe sequence and flags while it is running.
// Assumes a single clock; load wins over the running count.
`timescale 1ns/100ps
module gps_timer #(
  parameter WIDTH = 5
) (
  // Clock and reset.
  input wire clock_i,
  input wire rst_n_i,
  // Start and length of the sequence.
  input wire load_i,
  input wire [WIDTH-1:0] count_i,
  // Running state.
  output wire busy_o,
  output wire [WIDTH-1:0] left_o
);

  reg [WIDTH-1:0] cnt_q;

  // A fresh load restarts the sequence even if one is still running.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt_q <= {WIDTH{1'b0}};
    end else if (load_i) begin
      cnt_q <= count_i;
    end else if (cnt_q != {WIDTH{1'b0}}) begin
      cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign busy_o = (cnt_q != {WIDTH{1'b0}});
  assign left_o = cnt_q;

endmodule

//--- tb/gps_ext_model.sv
// Model of the external input buffer and output latches on the shared lines.
// Assumes active-low strobes that change just after the rising clock edge.
`timescale 1ns/100ps
module gps_ext_model (
  // Clock.
  input wire clock_i,
  // Port side.
  input wire ws_i, io_i, sd_oe_i,
  input wire [3:0] ld_i, ld_oe_i,
  input wire [7:0] sd_hi_i,
  // Bench control, line levels and captured values.
  input wire drive_i,
  input wire [3:0] nib_i,
  input wire [7:0] buf_i,
  output wire [7:0] ld_o,
  output wire [7:0] sd_o,
  output reg [3:0] nib_q_o,
  output reg [7:0] byte_q_o
);
  reg ws_q = 1'b1;
  reg done_q = 1'b0;
  // Released lines show the inverse, so a late capture cannot pass by luck.
  assign ld_o = {(drive_i && !done_q) ? nib_i : ~nib_i, ld_i ~^ ld_oe_i};
  // The buffer answers read strobes only, never a write cycle.
  assign sd_o = (!io_i && !sd_oe_i) ? buf_i : ~buf_i;
  // Nibble latch on the strobe rising edge; byte latch gated by the write cycle.
  always @(posedge clock_i) begin
    ws_q <= ws_i;
    if (!drive_i) done_q <= 1'b0;
    if (!ws_q && ws_i) begin
      done_q <= 1'b1;
      if (ld_oe_i == 4'hF) nib_q_o <= ld_i;
    end
    if (!io_i && sd_oe_i) byte_q_o <= sd_hi_i;
  end
endmodule

//--- tb/gps_port_checker.sv
// Checker for the general I/O port: strobe timing, line drive and static pins.
// Assumes it is bound to gps_port and sees only that module's ports.
`timescale 1ns/100ps
module gps_port_checker #(
  parameter IN_CYCLES = 19,
  parameter OUT_CYCLES = 7
) (
  input wire clock_i, rst_n_i, pci_mode_i, input_read_enable_i, local_bus_other_use_i,
  input wire port_trigger_we_i, dac_index_read_i, input_read_valid_o, system_data_bus_hi_oe_o,
  input wire port_write_strobe_o, port_io_strobe_o, rom_chip_select_n_o, rom_select_req_i,
  input wire [1:0] strobe_routing_field_i,
  input wire [3:0] local_data_lines_oe_o,
  input wire [7:0] port_trigger_wdata_i, port_trigger_register_o, port_data_register_o,
  input wire [7:0] local_data_lines_i, system_data_bus_hi_o
);
  // -------------------------------------------------------------------------
  // One clock domain; a reset drops every attempt in flight.
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // A trigger only starts a sequence with routing 01b and the local bus free.
  wire go = port_trigger_we_i && strobe_routing_field_i == 2'h1 && !local_bus_other_use_i;
  wire [3:0] up_nib = local_data_lines_i[7:4];
  wire [1:0] trg = port_trigger_register_o[1:0];

  a_pci_strobe_width: assert property (pci_mode_i && go |=> !port_write_strobe_o [*2] ##1 port_write_strobe_o)
    else $error("pci strobe width wrong");
  a_pci_line_hold: assert property (pci_mode_i && go |=> local_data_lines_oe_o == 4'hF [*3] ##1 local_data_lines_oe_o == 4'h0)
    else $error("pci line drive wrong");
  a_pci_capture: assert property (pci_mode_i && go |=> ##2 port_data_register_o[7:4] == $past(up_nib, 5))
    else $error("pci capture wrong");
  a_vl_out_byte: assert property (!pci_mode_i && go |=> system_data_bus_hi_oe_o && !port_io_strobe_o
    && system_data_bus_hi_o == $past(port_trigger_wdata_i))
    else $error("vl output byte wrong");
  a_vl_out_width: assert property (!pci_mode_i && go |=> !port_io_strobe_o [*6] ##[1:2] port_io_strobe_o)
    else $error("vl output strobe width wrong");
  a_vl_in_cycle: assert property (dac_index_read_i && input_read_enable_i && !pci_mode_i && go == 1'b0
    && strobe_routing_field_i == 2'h1 && !local_bus_other_use_i
    |=> !port_io_strobe_o ##[16:20] input_read_valid_o)
    else $error("vl input cycle wrong");
  a_pci_two_bit: assert property ((pci_mode_i && strobe_routing_field_i[1] && $stable(trg)) [*3]
    |-> port_io_strobe_o == trg[0] && port_write_strobe_o == trg[1])
    else $error("pci static pins wrong");
  a_vl_two_bit: assert property ((!pci_mode_i && strobe_routing_field_i == 2'h3 && $stable(trg)) [*3]
    |-> port_io_strobe_o == trg[0] && rom_chip_select_n_o == trg[1])
    else $error("vl two-bit pins wrong");
  a_vl_one_bit: assert property ((!pci_mode_i && strobe_routing_field_i == 2'h2 && $stable(trg)
    && $stable(rom_select_req_i)) [*3]
    |-> port_io_strobe_o == trg[0] && rom_chip_select_n_o == !rom_select_req_i)
    else $error("vl one-bit pins wrong");
  a_idle_high: assert property ((strobe_routing_field_i == 2'h0) [*3] |-> port_io_strobe_o && port_write_strobe_o)
    else $error("idle pins not high");

  c_pci_go: cover property (pci_mode_i && go);
  c_vl_go: cover property (!pci_mode_i && go);
  c_vl_in: cover property (input_read_valid_o);
endmodule

bind gps_port gps_port_checker #(.IN_CYCLES(IN_CYCLES), .OUT_CYCLES(OUT_CYCLES)) u_gps_port_checker (.*);

//--- tb/gps_port_tb_top.sv
// Self-checking bench for gps_port with the external latch and buffer model.
// Assumes default cycle parameters; inputs change by non-blocking assignment at rising edges.
`timescale 1ns/100ps
module gps_port_tb_top;
  reg clock_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg pci = 1'b0, ren = 1'b0, oth = 1'b0, twe = 1'b0, dwe = 1'b0, dac = 1'b0, rreq = 1'b0, drv = 1'b0;
  reg [1:0] rt = 2'h0;
  reg [7:0] twd = 8'h00, dwd = 8'h00, tv = 8'h00;
  wire [7:0] trg_q, dat_q, rd_q, ld_in, sd_in, sd_hi, byte_q;
  wire [3:0] ld_out, ld_oe, nib_q;
  wire rd_v, ws, io, rom, sd_oe, busy;
  integer err_total = 0;
  integer tests_run = 0;
  integer i;
  always #5 clock_i = ~clock_i;

  gps_port u_gps_port (.clock_i(clock_i), .rst_n_i(rst_n_i), .pci_mode_i(pci), .strobe_routing_field_i(rt),
    .input_read_enable_i(ren), .local_bus_other_use_i(oth), .port_trigger_we_i(twe), .port_trigger_wdata_i(twd),
    .port_data_we_i(dwe), .port_data_wdata_i(dwd), .dac_index_read_i(dac), .port_trigger_register_o(trg_q),
    .port_data_register_o(dat_q), .input_read_data_o(rd_q), .input_read_valid_o(rd_v), .port_busy_o(busy),
    .local_data_lines_i(ld_in), .local_data_lines_o(ld_out), .local_data_lines_oe_o(ld_oe),
    .system_data_bus_i(sd_in), .system_data_bus_hi_o(sd_hi), .system_data_bus_hi_oe_o(sd_oe),
    .port_write_strobe_o(ws), .port_io_strobe_o(io), .rom_chip_select_n_o(rom), .rom_select_req_i(rreq));
  gps_ext_model u_gps_ext_model (.clock_i(clock_i), .ws_i(ws), .io_i(io), .sd_oe_i(sd_oe), .ld_i(ld_out),
    .ld_oe_i(ld_oe), .sd_hi_i(sd_hi), .drive_i(drv), .nib_i(4'h3), .buf_i(8'h5A), .ld_o(ld_in), .sd_o(sd_in),
    .nib_q_o(nib_q), .byte_q_o(byte_q));

  // Compare one value and count it; a difference is reported at once.
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  // Wait n edges, then let the edge's updates settle before looking.
  task step(input integer n);
    begin
      repeat (n) @(posedge clock_i);
      #1;
    end
  endtask
  // One-cycle trigger write; returns in the first cycle after the taking edge.
  task trig(input [7:0] v);
    begin
      @(posedge clock_i);
      twe <= 1'b1;
      twd <= v;
      @(posedge clock_i);
      twe <= 1'b0;
      #1;
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Reset state: pins high, lines released, registers clear.
  task t_reset;
    begin
      chk({ws, io, rom}, 8'h07);
      chk(ld_oe, 4'h0);
      chk(trg_q | dat_q, 8'h00);
    end
  endtask
  // PCI port: nibble out and in, then a refused trigger while the bus is in use.
  task t_pci;
    begin
      @(posedge clock_i);
      pci <= 1'b1;
      rt <= 2'h1;
      drv <= 1'b1;
      dwe <= 1'b1;
      dwd <= 8'hA5;
      @(posedge clock_i);
      dwe <= 1'b0;
      step(5);
      trig(8'h00);
      chk({ws, ld_out}, 8'h05);
      chk(ld_oe, 4'hF);
      step(2);
      chk(ws, 1'b1);
      chk(dat_q, 8'h35);
      chk(busy, 1'b1);
      step(1);
      chk(ld_oe, 4'h0);
      chk(nib_q, 4'h5);
      @(posedge clock_i);
      oth <= 1'b1;
      trig(8'h00);
      step(3);
      chk({ws, dat_q}, 9'h135);
      @(posedge clock_i);
      oth <= 1'b0;
      drv <= 1'b0;
    end
  endtask
  // Static modes: PCI two-bit, VL two-bit, VL one-bit, each bit set in turn.
  task t_static;
    begin
      rreq <= 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
        tv = (i % 2) ? 8'h02 : 8'h01;
        @(posedge clock_i);
        pci <= (i < 2);
        rt <= (i / 2 == 1) ? 2'h3 : 2'h2;
        trig(tv);
        step(3);
        chk(io, tv[0]);
        chk((i < 2) ? ws : rom, (i < 4) ? tv[1] : 1'b0);
      end
    end
  endtask
  // VL output byte then VL input read through the buffer.
  task t_vl;
    begin
      @(posedge clock_i);
      pci <= 1'b0;
      rt <= 2'h1;
      trig(8'hC3);
      chk({sd_oe, io, sd_hi}, 10'h2C3);
      step(8);
      chk({io, byte_q}, 9'h1C3);
      @(posedge clock_i);
      ren <= 1'b1;
      dac <= 1'b1;
      @(posedge clock_i);
      dac <= 1'b0;
      #1;
      chk(io, 1'b0);
      i = 1;
      while (rd_v !== 1'b1 && i < 40) begin
        step(1);
        i = i + 1;
      end
      chk(rd_q, 8'h5A);
      chk(i >= 17 && i <= 21, 1'b1);
      chk(byte_q, 8'hC3);
    end
  endtask

  initial begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    step(2);
    t_reset;
    t_pci;
    t_static;
    t_vl;
    tally_and_finish;
  end
  // Watchdog at 2000 cycles, well beyond the roughly 100 cycles the run needs.
  initial begin
    #20000;
    err_total = err_total + 1;
    tally_and_finish;
  end
endmodule
